/* rtl/cipher_defines.vh */
`ifndef CIPHER_DEFINES_VH
`define CIPHER_DEFINES_VH

// Host window
`define ADDR_STATUS 8'h82
`define ADDR_CTRL 8'h83
`define ADDR_PAGE_FIRST 8'h84
`define ADDR_PAGE_LAST 8'h93
`define ADDR_CTRL_COPY 8'h94

// Serial command byte, top two bits
`define CMD_SRAM_READ 2'h0
`define CMD_SRAM_WRITE 2'h1

// Control byte fields
`define CTRL_REQUEST_BIT 7
`define CTRL_MODE_HI 6
`define CTRL_MODE_LO 4
`define CTRL_DIR_BIT 3

// Mode field values
`define MODE_ECB 3'h0
`define MODE_KEY 3'h1
`define MODE_CBC 3'h2

// Reset values
`define CTRL_MODE_RESET 3'h0
`define CTRL_DIR_RESET 1'b0

// Round constants
`define RCON_ENC_FIRST 8'h01
`define RCON_DEC_FIRST 8'h36
`define AES_ROUNDS 4'ha

// Timing
`define CIPHER_OP_TIME_NS 23400
`define CORE_CLK_PERIOD_NS 25

`endif

/* rtl/cipher_window_engine.v */
// Notes on behaviour
// - AES with 128-bit key and 128-bit block.
// - ECB encrypt and decrypt, CBC encrypt only.
// - Cipher runs on its own, independent of radio datapath.
// - Control only through SRAM accesses at 0x82 to 0x94.
// - Fast access returns previous result bytes while new bytes are written.
// - Initial key kept in separate register never altered by operations.
// - Mode 1 in control byte 0x83 enters key loading.
// - Page at 0x84..0x93 is key or data, chosen by current mode.
// - Input block goes to data page 0x84 through 0x93.
// - Request bit written at 0x83 or mirror 0x94 starts operation.
// - Mode, data and start accepted in one write burst.
// - No other transceiver register access needed.
// - No host access during sleep or reset.
// - Reset clears configuration, data page and keys.
// - Key page reads last round key of previous operation.
// - Each operation starts from stored initial key.
// - Mode 0 selects ECB.
// - Mode 2 selects chaining; each block uses the previous result of any mode, which is zero only after reset.
// - Chaining XORs previous result with new input, then encrypts.
// - One block operation takes 23.4 us.
`timescale 1ns/100ps
`include "cipher_defines.vh"

module cipher_window_engine #(
    parameter OP_CYCLES = (`CIPHER_OP_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS
) (
    input wire CORE_CLK,
    input wire RST,
    input wire SLEEP,
    input wire SCLK,
    input wire MOSI,
    input wire SEL_N,
    output reg MISO,
    output reg ENGINE_BUSY
);

    function [7:0] gmul;
        input [7:0] a;
        input [7:0] b;
        reg [7:0] p, x;
        integer i;
        begin
            p = 8'h00;
            x = a;
            for (i = 0; i < 8; i = i + 1) begin
                if (b[i])
                    p = p ^ x;
                x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
            end
            gmul = p;
        end
    endfunction

    // Field inverse as x^254; zero maps to zero
    function [7:0] ginv;
        input [7:0] x;
        reg [7:0] r;
        integer i;
        begin
            r = 8'h01;
            for (i = 7; i >= 0; i = i - 1) begin
                r = gmul(r, r);
                if (i != 0)
                    r = gmul(r, x);
            end
            ginv = r;
        end
    endfunction

    function [7:0] sbox;
        input [7:0] x;
        reg [7:0] b;
        begin
            b = ginv(x);
            sbox = b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]}
                ^ {b[3:0], b[7:4]} ^ 8'h63;
        end
    endfunction

    function [7:0] isbox;
        input [7:0] x;
        begin
            isbox = ginv({x[6:0], x[7]} ^ {x[4:0], x[7:5]} ^ {x[1:0], x[7:2]} ^ 8'h05);
        end
    endfunction

    function [31:0] sub_rot;
        input [31:0] w;
        begin
            sub_rot = {sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
        end
    endfunction

    function [127:0] key_fwd;
        input [127:0] k;
        input [7:0] rc;
        reg [31:0] n0, n1, n2;
        begin
            n0 = k[127:96] ^ sub_rot(k[31:0]) ^ {rc, 24'h000000};
            n1 = k[95:64] ^ n0;
            n2 = k[63:32] ^ n1;
            key_fwd = {n0, n1, n2, k[31:0] ^ n2};
        end
    endfunction

    function [127:0] key_back;
        input [127:0] k;
        input [7:0] rc;
        reg [31:0] p3;
        begin
            p3 = k[31:0] ^ k[63:32];
            key_back = {k[127:96] ^ sub_rot(p3) ^ {rc, 24'h000000},
                k[127:96] ^ k[95:64], k[95:64] ^ k[63:32], p3};
        end
    endfunction

    // Forward round: substitute, shift rows, optional mix, add key
    function [127:0] enc_round;
        input [127:0] s;
        input [127:0] k;
        input last;
        reg [127:0] t;
        reg [7:0] a0, a1, a2, a3;
        integer r, c;
        begin
            t = 128'h0;
            for (c = 0; c < 4; c = c + 1)
                for (r = 0; r < 4; r = r + 1)
                    t[127 - 8 * (r + 4 * c) -: 8] = sbox(s[127 - 8 * (r + 4 * ((c + r) % 4)) -: 8]);
            if (!last)
                for (c = 0; c < 4; c = c + 1) begin
                    a0 = t[127 - 32 * c -: 8];
                    a1 = t[119 - 32 * c -: 8];
                    a2 = t[111 - 32 * c -: 8];
                    a3 = t[103 - 32 * c -: 8];
                    t[127 - 32 * c -: 8] = gmul(a0, 8'h02) ^ gmul(a1, 8'h03) ^ a2 ^ a3;
                    t[119 - 32 * c -: 8] = a0 ^ gmul(a1, 8'h02) ^ gmul(a2, 8'h03) ^ a3;
                    t[111 - 32 * c -: 8] = a0 ^ a1 ^ gmul(a2, 8'h02) ^ gmul(a3, 8'h03);
                    t[103 - 32 * c -: 8] = gmul(a0, 8'h03) ^ a1 ^ a2 ^ gmul(a3, 8'h02);
                end
            enc_round = t ^ k;
        end
    endfunction

    // Inverse round: inverse shift and substitute, add key, optional inverse mix
    function [127:0] dec_round;
        input [127:0] s;
        input [127:0] k;
        input last;
        reg [127:0] t;
        reg [7:0] a0, a1, a2, a3;
        integer r, c;
        begin
            t = 128'h0;
            for (c = 0; c < 4; c = c + 1)
                for (r = 0; r < 4; r = r + 1)
                    t[127 - 8 * (r + 4 * ((c + r) % 4)) -: 8] = isbox(s[127 - 8 * (r + 4 * c) -: 8]);
            t = t ^ k;
            if (!last)
                for (c = 0; c < 4; c = c + 1) begin
                    a0 = t[127 - 32 * c -: 8];
                    a1 = t[119 - 32 * c -: 8];
                    a2 = t[111 - 32 * c -: 8];
                    a3 = t[103 - 32 * c -: 8];
                    t[127 - 32 * c -: 8] = gmul(a0, 8'h0e) ^ gmul(a1, 8'h0b)
                        ^ gmul(a2, 8'h0d) ^ gmul(a3, 8'h09);
                    t[119 - 32 * c -: 8] = gmul(a0, 8'h09) ^ gmul(a1, 8'h0e)
                        ^ gmul(a2, 8'h0b) ^ gmul(a3, 8'h0d);
                    t[111 - 32 * c -: 8] = gmul(a0, 8'h0d) ^ gmul(a1, 8'h09)
                        ^ gmul(a2, 8'h0e) ^ gmul(a3, 8'h0b);
                    t[103 - 32 * c -: 8] = gmul(a0, 8'h0b) ^ gmul(a1, 8'h0d)
                        ^ gmul(a2, 8'h09) ^ gmul(a3, 8'h0e);
                end
            dec_round = t;
        end
    endfunction

    reg sclk_s1_r, sclk_s2_r, sclk_s3_r;
    reg mosi_s1_r, mosi_s2_r;
    reg sel_s1_r, sel_s2_r, sel_s3_r;
    reg [2:0] bit_cnt_r;
    reg [1:0] byte_cnt_r;
    reg [1:0] cmd_r;
    reg [7:0] addr_r;
    reg [7:0] in_sh_r;
    reg [7:0] out_byte_r;
    reg [2:0] mode_r;
    reg dir_r;
    reg done_r;
    reg [127:0] key_init_r;
    reg [127:0] key_work_r;
    reg [127:0] data_r;
    reg [127:0] state_r, cbc_prev_r;
    reg run_r;
    reg [3:0] round_r;
    reg [7:0] rcon_r;
    reg [9:0] op_cnt_r;

    wire active = ~sel_s2_r & ~SLEEP;
    wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
    wire sclk_fall = ~sclk_s2_r & sclk_s3_r;
    wire sel_start = ~sel_s2_r & sel_s3_r;
    wire byte_done = active & sclk_rise & (bit_cnt_r == 3'h7);
    wire [7:0] in_byte = {in_sh_r[6:0], mosi_s2_r};
    wire in_page = (addr_r >= `ADDR_PAGE_FIRST) && (addr_r <= `ADDR_PAGE_LAST);
    wire is_ctrl = (addr_r == `ADDR_CTRL) || (addr_r == `ADDR_CTRL_COPY);
    wire host_wr = byte_done && (byte_cnt_r == 2'h2) && (cmd_r == `CMD_SRAM_WRITE);
    wire [3:0] page_idx = addr_r[3:0] - 4'h4;
    wire [7:0] addr_inc = addr_r + 8'h01;
    wire start_req = host_wr && is_ctrl && in_byte[`CTRL_REQUEST_BIT]
        && (in_byte[`CTRL_MODE_HI:`CTRL_MODE_LO] != `MODE_KEY) && !ENGINE_BUSY;
    wire new_cbc = (in_byte[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_CBC);
    wire new_dec = in_byte[`CTRL_DIR_BIT] && !new_cbc;
    wire last_round = (round_r == `AES_ROUNDS);
    wire [127:0] kf = key_fwd(key_work_r, rcon_r);
    wire [127:0] kb = key_back(key_work_r, rcon_r);
    wire [127:0] round_out = dir_r ? dec_round(state_r, kb, last_round)
        : enc_round(state_r, kf, last_round);

    // Window read map; reserved and unmapped bytes read zero
    function [7:0] window_read;
        input [7:0] a;
        begin
            if (a == `ADDR_STATUS)
                window_read = {6'h00, ENGINE_BUSY, done_r};
            else if (a == `ADDR_CTRL || a == `ADDR_CTRL_COPY)
                window_read = {ENGINE_BUSY, mode_r, dir_r, 3'h0};
            else if (a >= `ADDR_PAGE_FIRST && a <= `ADDR_PAGE_LAST)
                window_read = (mode_r == `MODE_KEY)
                    ? key_work_r[127 - 8 * (a - `ADDR_PAGE_FIRST) -: 8]
                    : data_r[127 - 8 * (a - `ADDR_PAGE_FIRST) -: 8];
            else
                window_read = 8'h00;
        end
    endfunction

    always @(posedge CORE_CLK) begin
        if (RST) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            mosi_s1_r <= 1'b0;
            mosi_s2_r <= 1'b0;
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
            sel_s3_r <= 1'b1;
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 2'h0;
            cmd_r <= 2'h3;
            addr_r <= 8'h00;
            in_sh_r <= 8'h00;
            out_byte_r <= 8'h00;
            MISO <= 1'b0;
            mode_r <= `CTRL_MODE_RESET;
            dir_r <= `CTRL_DIR_RESET;
            done_r <= 1'b0;
            key_init_r <= 128'h0;
            key_work_r <= 128'h0;
            data_r <= 128'h0;
            state_r <= 128'h0;
            cbc_prev_r <= 128'h0;
            ENGINE_BUSY <= 1'b0;
            run_r <= 1'b0;
            round_r <= 4'h0;
            rcon_r <= 8'h00;
            op_cnt_r <= 10'h000;
        end else begin
            sclk_s1_r <= SCLK;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            mosi_s1_r <= MOSI;
            mosi_s2_r <= mosi_s1_r;
            sel_s1_r <= SEL_N;
            sel_s2_r <= sel_s1_r;
            sel_s3_r <= sel_s2_r;

            // Serial framing; sleep holds the port dead
            if (!active) begin
                bit_cnt_r <= 3'h0;
                byte_cnt_r <= 2'h0;
                MISO <= 1'b0;
            end else if (sel_start) begin
                bit_cnt_r <= 3'h0;
                byte_cnt_r <= 2'h0;
                out_byte_r <= {6'h00, ENGINE_BUSY, done_r};
            end else begin
                if (sclk_rise) begin
                    in_sh_r <= in_byte;
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                end
                if (sclk_fall)
                    MISO <= out_byte_r[3'h7 - bit_cnt_r];
                if (byte_done) begin
                    if (byte_cnt_r == 2'h0) begin
                        cmd_r <= in_byte[7:6];
                        out_byte_r <= 8'h00;
                        byte_cnt_r <= 2'h1;
                    end else if (byte_cnt_r == 2'h1) begin
                        addr_r <= in_byte;
                        out_byte_r <= (cmd_r == `CMD_SRAM_READ) ? window_read(in_byte) : 8'h00;
                        byte_cnt_r <= 2'h2;
                    end else begin
                        addr_r <= addr_inc;
                        // Writes hand back the old byte one slot later
                        out_byte_r <= (cmd_r == `CMD_SRAM_READ) ? window_read(addr_inc)
                            : window_read(addr_r);
                    end
                end
            end

            // Cipher sequencing, free of the radio datapath
            if (run_r) begin
                state_r <= round_out;
                key_work_r <= dir_r ? kb : kf;
                rcon_r <= dir_r ? ((rcon_r == 8'h1b) ? 8'h80 : {1'b0, rcon_r[7:1]})
                    : gmul(rcon_r, 8'h02);
                round_r <= round_r + 4'h1;
                if (last_round)
                    run_r <= 1'b0;
            end
            if (ENGINE_BUSY) begin
                op_cnt_r <= op_cnt_r + 10'h001;
                if (op_cnt_r == OP_CYCLES[9:0] - 10'h001) begin
                    ENGINE_BUSY <= 1'b0;
                    done_r <= 1'b1;
                    data_r <= state_r;
                    cbc_prev_r <= state_r;
                end
            end

            // Host writes; a byte landing with a completion wins over the result
            if (host_wr && active) begin
                if (is_ctrl) begin
                    mode_r <= in_byte[`CTRL_MODE_HI:`CTRL_MODE_LO];
                    dir_r <= in_byte[`CTRL_DIR_BIT];
                end else if (in_page) begin
                    if (mode_r == `MODE_KEY) begin
                        key_init_r[127 - 8 * page_idx -: 8] <= in_byte;
                        key_work_r[127 - 8 * page_idx -: 8] <= in_byte;
                    end else begin
                        data_r[127 - 8 * page_idx -: 8] <= in_byte;
                    end
                end
            end

            // Start takes the block as written so far in this burst
            if (start_req && active) begin
                ENGINE_BUSY <= 1'b1;
                done_r <= 1'b0;
                run_r <= 1'b1;
                round_r <= 4'h1;
                op_cnt_r <= 10'h000;
                dir_r <= new_dec;
                key_work_r <= key_init_r;
                rcon_r <= new_dec ? `RCON_DEC_FIRST : `RCON_ENC_FIRST;
                if (new_cbc)
                    state_r <= data_r ^ cbc_prev_r ^ key_init_r;
                else
                    state_r <= data_r ^ key_init_r;
            end
        end
    end
endmodule // cipher_window_engine

/* tb/cipher_window_monitor.sv */
`timescale 1ns/100ps
module cipher_window_monitor #(
    parameter OP_CYCLES = 936
) (
    input wire CORE_CLK,
    input wire RST,
    input wire SLEEP,
    input wire SCLK,
    input wire MOSI,
    input wire SEL_N,
    input wire MISO,
    input wire ENGINE_BUSY
);
    reg [15:0] busy_cnt_r;
    wire [15:0] busy_cnt_nxt = (RST || !ENGINE_BUSY) ? 16'h0000 : busy_cnt_r + 16'h0001;

    always @(posedge CORE_CLK) begin
        busy_cnt_r <= busy_cnt_nxt;
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_reset_quiet: assert property (disable iff (1'b0) RST |=> !ENGINE_BUSY && !MISO)
        else $error("outputs not cleared by reset");
    a_release_idle: assert property ($fell(RST) |-> !ENGINE_BUSY ##1 !ENGINE_BUSY)
        else $error("engine busy right after reset");
    a_sleep_quiet: assert property (SLEEP ##1 SLEEP |-> !MISO)
        else $error("serial output driven while asleep");
    a_idle_quiet: assert property (SEL_N [*5] |-> !MISO)
        else $error("serial output driven while deselected");
    a_busy_length: assert property ($fell(ENGINE_BUSY) |-> busy_cnt_r == OP_CYCLES)
        else $error("operation length wrong");
    a_busy_holds: assert property ($rose(ENGINE_BUSY) |-> ENGINE_BUSY [*8])
        else $error("busy dropped too early");
    a_start_selected: assert property ($rose(ENGINE_BUSY) |-> !$past(SEL_N, 2))
        else $error("operation started outside a frame");
    a_miso_stands: assert property ((!SEL_N && SCLK && !SLEEP) [*4] |-> $stable(MISO))
        else $error("serial output changed without a clock fall");

    c_start: cover property ($rose(ENGINE_BUSY));
    c_done: cover property ($fell(ENGINE_BUSY));
    c_sleep_frame: cover property (SLEEP && !SEL_N);
endmodule // cipher_window_monitor

bind cipher_window_engine cipher_window_monitor #(.OP_CYCLES(OP_CYCLES)) mon (
    .CORE_CLK(CORE_CLK), .RST(RST), .SLEEP(SLEEP), .SCLK(SCLK), .MOSI(MOSI),
    .SEL_N(SEL_N), .MISO(MISO), .ENGINE_BUSY(ENGINE_BUSY));

/* tb/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
    input wire CORE_CLK,
    input wire MISO,
    output reg SCLK,
    output reg MOSI,
    output reg SEL_N
);
    logic [7:0] tx [0:31];
    logic [7:0] rx [0:31];

    initial begin
        SCLK = 1'b0;
        MOSI = 1'b0;
        SEL_N = 1'b1;
    end

    // Mode 0, MSB first; the serial clock stands low outside frames
    task automatic frame(input int n);
        int i;
        int b;
        SEL_N = 1'b0;
        for (i = 0; i < n; i++) begin
            for (b = 7; b >= 0; b--) begin
                MOSI = tx[i][b];
                repeat (4) @(negedge CORE_CLK);
                SCLK = 1'b1;
                rx[i][b] = MISO;
                repeat (4) @(negedge CORE_CLK);
                SCLK = 1'b0;
            end
        end
        repeat (8) @(negedge CORE_CLK);
        SEL_N = 1'b1;
        MOSI = ~MOSI; // Released line shows no stale data
        repeat (6) @(negedge CORE_CLK);
    endtask
endmodule // spi_host_model

/* tb/tb_aes128_sram_window_engine.sv */
`timescale 1ns/100ps
module tb_aes128_sram_window_engine;
    localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
    localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
    localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
    localparam logic [127:0] LRK = 128'h13111d7fe3944a17f307a78b4d2b30c5;
    logic core_clk;
    logic rst;
    logic sleep;
    wire sclk;
    wire mosi;
    wire sel_n;
    wire miso;
    wire engine_busy;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [127:0] prior;

    cipher_window_engine #(.OP_CYCLES(12)) uut (.CORE_CLK(core_clk), .RST(rst), .SLEEP(sleep),
        .SCLK(sclk), .MOSI(mosi), .SEL_N(sel_n), .MISO(miso), .ENGINE_BUSY(engine_busy));
    spi_host_model host (.CORE_CLK(core_clk), .MISO(miso), .SCLK(sclk), .MOSI(mosi),
        .SEL_N(sel_n));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bytes: command, address, byte 2, a 16 byte block, byte 19
    task automatic burst(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] b2,
        input logic [127:0] data, input logic [7:0] b19, input int n);
        int i;
        host.tx[0] = cmd;
        host.tx[1] = addr;
        host.tx[2] = b2;
        for (i = 0; i < 16; i++) host.tx[3 + i] = data[127 - 8 * i -: 8];
        host.tx[19] = b19;
        host.tx[20] = 8'h00;
        host.frame(n);
    endtask

    function automatic logic [127:0] page(input int base);
        logic [127:0] v;
        for (int i = 0; i < 16; i++) v[127 - 8 * i -: 8] = host.rx[base + i];
        return v;
    endfunction

    // One burst with mode, block and start, then the whole window read back
    task automatic run(input logic [7:0] ctrl, input logic [127:0] data);
        int k;
        burst(8'h40, 8'h83, ctrl, data, ctrl | 8'h80, 20);
        prior = page(4);
        for (k = 0; k < 100 && engine_busy !== 1'b0; k++) @(negedge core_clk);
        chk({127'h0, engine_busy}, 128'h0);
        burst(8'h00, 8'h82, 8'h00, 128'h0, 8'h00, 21);
    endtask

    task automatic t_reset_state();
        burst(8'h00, 8'h82, 8'h00, 128'h0, 8'h00, 21);
        chk({104'h0, host.rx[2], host.rx[3], host.rx[20]}, 128'h0);
        chk(page(4), 128'h0);
        burst(8'h00, 8'h95, 8'h00, 128'h0, 8'h00, 3);
        chk({120'h0, host.rx[2]}, 128'h0);
    endtask

    task automatic t_key_load();
        burst(8'h40, 8'h83, 8'h10, KEY, 8'h00, 19);
        burst(8'h00, 8'h84, 8'h00, 128'h0, 8'h00, 18);
        chk(page(2), KEY);
    endtask

    task automatic t_ecb_encrypt();
        run(8'h00, PT);
        chk({104'h0, host.rx[2], host.rx[3], host.rx[20]}, 128'h010000);
        chk(page(4), CT);
        run(8'h00, PT);
        chk(prior, CT);
        chk(page(4), CT);
    endtask

    task automatic t_key_page(input logic [127:0] exp);
        burst(8'h40, 8'h83, 8'h10, 128'h0, 8'h00, 3);
        burst(8'h00, 8'h84, 8'h00, 128'h0, 8'h00, 18);
        chk(page(2), exp);
    endtask

    task automatic t_cbc();
        run(8'h20, CT ^ PT);
        chk(page(4), CT);
    endtask

    task automatic t_decrypt();
        burst(8'h40, 8'h83, 8'h10, LRK, 8'h00, 19);
        run(8'h08, CT);
        chk(page(4), PT);
        chk({120'h0, host.rx[3]}, 128'h08);
    endtask

    task automatic t_sleep();
        sleep = 1'b1;
        burst(8'h40, 8'h83, 8'h20, 128'h0, 8'h00, 3);
        burst(8'h00, 8'h83, 8'h00, 128'h0, 8'h00, 4);
        chk({112'h0, host.rx[2], host.rx[3]}, 128'h0);
        sleep = 1'b0;
        burst(8'h00, 8'h83, 8'h00, 128'h0, 8'h00, 3);
        chk({120'h0, host.rx[2]}, 128'h08);
    endtask

    task automatic t_mid_reset();
        rst = 1'b1;
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_reset_state();
        t_key_page(128'h0);
        chk(page(2), 128'h0);
    endtask

    initial begin
        rst = 1'b1;
        sleep = 1'b0;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_reset_state();
        t_key_load();
        t_ecb_encrypt();
        t_key_page(LRK);
        t_cbc();
        t_decrypt();
        t_sleep();
        t_mid_reset();
        print_verdict();
    end
endmodule // tb_aes128_sram_window_engine
